// ---- src/gcr_map.svh ----
// Register offsets, field positions and reset values of the graphics control registers
`ifndef GCR_MAP_SVH
`define GCR_MAP_SVH
`define GCR_OFS_X 4'h0
`define GCR_OFS_Y 4'h1
`define GCR_OFS_DATA 4'h2
`define GCR_OFS_MAIN_CTRL 4'h4
`define GCR_OFS_PEN_LOW 4'h5
`define GCR_OFS_MAP_SEL 4'h6
`define GCR_OFS_PLANE_INH 4'h7
`define GCR_BIT_CPL 0
`define GCR_BIT_CLIP 1
`define GCR_BIT_VBUS_N 2
`define GCR_BIT_SHARED 3
`define GCR_BIT_DMA 4
`define GCR_BIT_FREEZE 5
`define GCR_BIT_BLINK 6
`define GCR_BIT_ALTERNATE_MAP_SET 7
`define GCR_PAN_LSB 8
`define GCR_XZOOM_LSB 11
`define GCR_YZOOM_LSB 14
`define GCR_CLIP_LSB 9
`define GCR_RST_MAIN_CTRL 16'h0000
`define GCR_RST_MAP_SEL 4'h0
`define GCR_RST_PLANE_INH 4'h0
`define GCR_PORTION_SMALL 10'h100
`define GCR_PORTION_LARGE 10'h200
`endif

// ---- src/gcr_pkg.sv ----
// Types shared by the graphics control register bank
package gcr_pkg;
   typedef logic [11:0] gcr_coord_t;
   typedef enum logic {GCR_SRC_HOST, GCR_SRC_DMA} gcr_src_t;
endpackage

// ---- src/gcr_regs.sv ----
// Graphics control register bank with display memory request FIFO
`include "gcr_map.svh"

module gcr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // Full at DEPTH entries; the count is one bit wider than the pointers
   assign in_ready_o = (count_reg < (AW+1)'(DEPTH));
   assign out_valid_o = (count_reg != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

module gcr_regs
   import gcr_pkg::*;
#(
   parameter int FIFO_DEPTH = 32,
   parameter logic [7:0] DMA_BASE_W = 8'h00
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Register port, one word per access
   input wire logic [3:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   output logic reg_ack_o,
   // DMA window byte port
   input wire logic [15:0] dma_addr_i,
   input wire logic dma_wr_i,
   input wire logic [7:0] dma_wdata_i,
   output logic dma_ack_o,
   // Straps
   input wire logic strap_double_res_i,
   input wire logic strap_y_step_512_i,
   input wire logic [7:0] strap_dma_base_i,
   // Display memory request stream
   output logic mem_valid_o,
   input wire logic mem_ready_i,
   output logic mem_complement_o,
   output logic mem_from_dma_o,
   output logic [3:0] mem_plane_inhibit_o,
   output logic [11:0] mem_x_o,
   output logic [11:0] mem_y_o,
   output logic [7:0] mem_data_o,
   // Display controls
   output logic clip_enable_o,
   output logic video_bus_enable_o,
   output logic interrupt_allow_o,
   output logic double_x_resolution_o,
   output logic dma_mode_o,
   output logic frame_freeze_o,
   output logic blink_allow_o,
   output logic [4:0] lut_select_o,
   output logic [2:0] horizontal_zoom_factor_o,
   output logic [1:0] vertical_zoom_factor_o,
   // Pan delay of horizontal sync
   input wire logic dot_en_i,
   input wire logic hsync_i,
   output logic hsync_o,
   // Light pen
   input wire logic pen_strobe_i,
   input wire logic [2:0] pen_x_i,
   input wire logic [2:0] pen_y_i,
   input wire logic pen_chip_read_i,
   output logic pen_full_o
);
   localparam int ENTRY_W = 1 + 1 + 4 + 12 + 12 + 8;

   logic [15:0] main_control_reg;
   logic [3:0] colour_map_select_reg;
   logic [3:0] plane_write_inhibit_reg;
   gcr_coord_t x_reg;
   gcr_coord_t y_reg;
   logic [9:0] byte_cnt_reg;
   logic [2:0] pen_x_low_reg;
   logic [2:0] pen_y_low_reg;
   logic pen_full_reg;
   logic [15:0] rdata_reg;
   logic rd_ack_reg;
   logic [7:1] hs_pipe_reg;
   logic hsync_reg;

   logic fifo_ready;
   logic push_valid;
   logic clipped;
   logic host_data_wr;
   logic host_wr_take;
   logic dma_hit;
   logic dma_take;
   logic [9:0] portion;
   logic [2:0] pan;
   gcr_coord_t push_x;
   gcr_coord_t push_y;
   gcr_src_t push_src;
   logic [7:0] push_data;
   logic [ENTRY_W-1:0] push_entry;
   logic [ENTRY_W-1:0] pop_entry;
   logic [15:0] rdata_next;

   assign pan = main_control_reg[`GCR_PAN_LSB +: 3];
   assign portion = strap_y_step_512_i ? `GCR_PORTION_LARGE : `GCR_PORTION_SMALL;

   // Window hit: fixed 256-byte block at the strapped base XOR DMA_BASE_W, only in DMA mode
   assign dma_hit = main_control_reg[`GCR_BIT_DMA]
                    && (dma_addr_i[15:8] == (strap_dma_base_i ^ DMA_BASE_W));
   assign host_data_wr = reg_wr_i && (reg_addr_i == `GCR_OFS_DATA);
   assign host_wr_take = reg_wr_i && (!host_data_wr || fifo_ready);
   assign dma_take = dma_wr_i && dma_hit && fifo_ready && !reg_wr_i;

   // DMA accesses use the coordinates after the pre-increment
   assign push_x = dma_take ? x_reg + 12'h001 : x_reg;
   assign push_y = (dma_take && byte_cnt_reg == 10'h000) ? y_reg + 12'h001 : y_reg;
   assign clipped = main_control_reg[`GCR_BIT_CLIP]
                    && ((push_x[11:`GCR_CLIP_LSB] != 3'h0)
                    || (push_y[11:`GCR_CLIP_LSB] != 3'h0));
   assign push_src = dma_take ? GCR_SRC_DMA : GCR_SRC_HOST;
   assign push_data = dma_take ? dma_wdata_i : reg_wdata_i[7:0];
   assign push_valid = ((host_data_wr && fifo_ready) || dma_take) && !clipped;
   assign push_entry = {main_control_reg[`GCR_BIT_CPL], push_src == GCR_SRC_DMA,
                        plane_write_inhibit_reg, push_y, push_x, push_data};

   gcr_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_valid),
      .in_ready_o(fifo_ready),
      .in_data_i(push_entry),
      .out_valid_o(mem_valid_o),
      .out_ready_i(mem_ready_i),
      .out_data_o(pop_entry)
   );

   assign {mem_complement_o, mem_from_dma_o, mem_plane_inhibit_o, mem_y_o, mem_x_o,
           mem_data_o} = pop_entry;

   assign reg_ack_o = host_wr_take || rd_ack_reg;
   assign dma_ack_o = dma_take;
   assign reg_rdata_o = rdata_reg;

   // Control registers; values hold until the next write
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         main_control_reg <= `GCR_RST_MAIN_CTRL;
         colour_map_select_reg <= `GCR_RST_MAP_SEL;
         plane_write_inhibit_reg <= `GCR_RST_PLANE_INH;
      end
      else if (host_wr_take)
      begin
         if (reg_addr_i == `GCR_OFS_MAIN_CTRL)
         begin
            main_control_reg <= reg_wdata_i;
         end
         else if (reg_addr_i == `GCR_OFS_MAP_SEL)
         begin
            colour_map_select_reg <= reg_wdata_i[3:0];
         end
         else if (reg_addr_i == `GCR_OFS_PLANE_INH)
         begin
            plane_write_inhibit_reg <= reg_wdata_i[3:0];
         end
      end
   end

   // Coordinates: host loads, DMA pre-increments
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         x_reg <= '0;
         y_reg <= '0;
         byte_cnt_reg <= '0;
      end
      else if (host_wr_take && reg_addr_i == `GCR_OFS_X)
      begin
         x_reg <= reg_wdata_i[11:0];
         byte_cnt_reg <= '0;
      end
      else if (host_wr_take && reg_addr_i == `GCR_OFS_Y)
      begin
         y_reg <= reg_wdata_i[11:0];
         byte_cnt_reg <= '0;
      end
      else if (dma_take)
      begin
         x_reg <= push_x;
         y_reg <= push_y;
         byte_cnt_reg <= (byte_cnt_reg == portion - 10'h001) ? '0 : byte_cnt_reg + 10'h001;
      end
   end

   // Light pen low bits and full flag; a strobe wins over a clearing read
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pen_x_low_reg <= '0;
         pen_y_low_reg <= '0;
         pen_full_reg <= 1'b0;
      end
      else if (pen_strobe_i)
      begin
         pen_x_low_reg <= pen_x_i;
         pen_y_low_reg <= pen_y_i;
         pen_full_reg <= 1'b1;
      end
      else if (pen_chip_read_i)
      begin
         pen_full_reg <= 1'b0;
      end
   end

   always_comb
   begin
      rdata_next = 16'h0000;
      if (reg_addr_i == `GCR_OFS_PEN_LOW)
      begin
         rdata_next = {10'h000, pen_y_low_reg, pen_x_low_reg};
      end
      else if (reg_addr_i == `GCR_OFS_X)
      begin
         rdata_next = {4'h0, x_reg};
      end
      else if (reg_addr_i == `GCR_OFS_Y)
      begin
         rdata_next = {4'h0, y_reg};
      end
   end

   // Read data answers one cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_reg <= '0;
         rd_ack_reg <= 1'b0;
      end
      else
      begin
         rd_ack_reg <= reg_rd_i && !reg_wr_i;
         if (reg_rd_i && !reg_wr_i)
         begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // Horizontal sync delay line, one stage per dot
   generate
      for (genvar i = 1; i <= 7; i++)
      begin : g_pan
         always_ff @(posedge clk_sys_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               hs_pipe_reg[i] <= 1'b0;
            end
            else if (dot_en_i)
            begin
               hs_pipe_reg[i] <= (i == 1) ? hsync_i : hs_pipe_reg[(i > 1) ? i - 1 : 1];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hsync_reg <= 1'b0;
      end
      else
      begin
         hsync_reg <= (pan == 3'h0) ? hsync_i : hs_pipe_reg[pan];
      end
   end

   assign hsync_o = hsync_reg;
   assign pen_full_o = pen_full_reg;
   assign clip_enable_o = main_control_reg[`GCR_BIT_CLIP];
   assign video_bus_enable_o = !main_control_reg[`GCR_BIT_VBUS_N];
   assign interrupt_allow_o = main_control_reg[`GCR_BIT_SHARED] && !strap_double_res_i;
   assign double_x_resolution_o = main_control_reg[`GCR_BIT_SHARED] && strap_double_res_i;
   assign dma_mode_o = main_control_reg[`GCR_BIT_DMA];
   assign frame_freeze_o = main_control_reg[`GCR_BIT_FREEZE];
   assign blink_allow_o = main_control_reg[`GCR_BIT_BLINK];
   assign lut_select_o = {main_control_reg[`GCR_BIT_ALTERNATE_MAP_SET], colour_map_select_reg};
   assign horizontal_zoom_factor_o = main_control_reg[`GCR_XZOOM_LSB +: 3];
   assign vertical_zoom_factor_o = main_control_reg[`GCR_YZOOM_LSB +: 2];

   sequence dma_byte_s;
      dma_take && !clipped;
   endsequence

   sequence portion_start_s;
      dma_take && byte_cnt_reg == 10'h000;
   endsequence

   cpl_push_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      host_data_wr && fifo_ready && !clipped && !mem_valid_o |=>
      mem_valid_o && mem_complement_o == $past(main_control_reg[`GCR_BIT_CPL]))
      else $error("complement flag not carried");
   clip_drop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      main_control_reg[`GCR_BIT_CLIP] && x_reg[11:9] != 3'h0 && host_data_wr |-> !push_valid)
      else $error("clipped access reached memory");
   vbus_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      host_wr_take && reg_addr_i == `GCR_OFS_MAIN_CTRL |=>
      video_bus_enable_o == !$past(reg_wdata_i[`GCR_BIT_VBUS_N]))
      else $error("video bus level wrong");
   bit3_route_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !(interrupt_allow_o && double_x_resolution_o)
      && (main_control_reg[3] == (interrupt_allow_o || double_x_resolution_o)))
      else $error("bit three misrouted");
   dma_xstep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dma_byte_s |=> x_reg == $past(x_reg) + 12'h001 && mem_valid_o)
      else $error("X not stepped before DMA byte");
   dma_ystep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      portion_start_s |=> y_reg == $past(y_reg) + 12'h001)
      else $error("Y not stepped at portion start");
   dma_ykeep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dma_take && byte_cnt_reg != 10'h000 |=> $stable(y_reg))
      else $error("Y stepped inside a portion");
   lut_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      host_wr_take && reg_addr_i == `GCR_OFS_MAP_SEL |=>
      lut_select_o[3:0] == $past(reg_wdata_i[3:0]))
      else $error("map select not loaded");
   pan_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pan == 3'h0 ##1 pan == 3'h0 |-> hsync_o == $past(hsync_i))
      else $error("undelayed sync wrong");
   pen_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pen_strobe_i ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == `GCR_OFS_PEN_LOW && !pen_strobe_i)
      |=> reg_rdata_o == {10'h000, $past(pen_y_i, 2), $past(pen_x_i, 2)} && reg_ack_o)
      else $error("pen low bits wrong");
   pen_full_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      pen_strobe_i |=> pen_full_o ##1 (pen_full_o || $past(pen_chip_read_i)))
      else $error("pen full flag lost");
   ctrl_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !(reg_wr_i && reg_addr_i == `GCR_OFS_MAIN_CTRL) |=> $stable(main_control_reg))
      else $error("control changed without write");
endmodule

// ---- test/gcr_host_model.sv ----
// Host processor and DMA master model driving the register port and DMA window
`include "gcr_map.svh"

module gcr_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Register port
   output logic [3:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [15:0] reg_wdata_o,
   input wire logic [15:0] reg_rdata_i,
   input wire logic reg_ack_i,
   // DMA window port
   output logic [15:0] dma_addr_o,
   output logic dma_wr_o,
   output logic [7:0] dma_wdata_o,
   input wire logic dma_ack_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic init_done_reg;

   initial
   begin
      reg_addr_o = 4'h0;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 16'h0000;
      dma_addr_o = 16'h0000;
      dma_wr_o = 1'b0;
      dma_wdata_o = 8'h00;
      init_done_reg = 1'b0;
   end

   // Whole word write held until acknowledged or 40 cycles pass; ok stays low when refused
   task automatic wr(input logic [3:0] addr, input logic [15:0] data, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      reg_wr_o <= 1'b1;
      while (!ok && n < 40)
      begin
         @(posedge clk_sys_i);
         ok = (reg_ack_i === 1'b1);
         n++;
      end
      reg_wr_o <= 1'b0;
      // Released data lines do not keep the last value
      reg_wdata_o <= ~data;
      @(posedge clk_sys_i);
   endtask

   // Main control is loaded twice on the first access only
   task automatic wr_ctrl(input logic [15:0] data);
      logic ok;
      if (!init_done_reg)
         wr(`GCR_OFS_MAIN_CTRL, data, ok);
      wr(`GCR_OFS_MAIN_CTRL, data, ok);
      init_done_reg = 1'b1;
   endtask

   task automatic rd(input logic [3:0] addr, output logic [15:0] data);
      int n;
      n = 0;
      data = 16'hxxxx;
      reg_addr_o <= addr;
      reg_rd_o <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_o <= 1'b0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (reg_ack_i !== 1'b1 && n < 8);
      if (reg_ack_i === 1'b1)
         data = reg_rdata_i;
   endtask

   task automatic dma(input logic [15:0] addr, input logic [7:0] data, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      dma_addr_o <= addr;
      dma_wdata_o <= data;
      dma_wr_o <= 1'b1;
      while (!ok && n < 10)
      begin
         @(posedge clk_sys_i);
         ok = (dma_ack_i === 1'b1);
         n++;
      end
      dma_wr_o <= 1'b0;
      dma_wdata_o <= ~data;
      @(posedge clk_sys_i);
   endtask
endmodule

// ---- test/tb_gcr_regs.sv ----
// Self-checking bench of the graphics control register bank
`include "gcr_map.svh"

module tb_gcr_regs;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [3:0] map;
      logic [5:0] flags;
      logic [4:0] lut;
      logic [2:0] hz;
      logic [1:0] vz;
   } gcr_row_t;

   logic clk_sys, rst_n, reg_wr, reg_rd, reg_ack, dma_wr, dma_ack, ok;
   logic [3:0] reg_addr, mem_inh;
   logic [15:0] reg_wdata, reg_rdata, dma_addr, rdv;
   logic [7:0] dma_wdata, strap_base, mem_data;
   logic strap_dbl, strap_512, mem_valid, mem_ready, mem_comp, mem_dma;
   logic [11:0] mem_x, mem_y;
   logic clip_en, vbus_en, irq_allow, dbl_res, dma_mode, freeze, blink;
   logic [4:0] lut;
   logic [2:0] hzoom, pen_x, pen_y;
   logic [1:0] vzoom;
   logic hsync_in, hsync_out, pen_strobe, pen_read, pen_full;
   logic [37:0] seen_q[$];
   int failures, tests_run, n;
   gcr_row_t rows [4] = '{
      '{16'h0000, 4'h0, 6'b000010, 5'h00, 3'h0, 2'h0},
      '{16'hffff, 4'hf, 6'b111101, 5'h1f, 3'h7, 2'h3},
      '{16'h4882, 4'h3, 6'b000011, 5'h13, 3'h1, 2'h1},
      '{16'h3768, 4'ha, 6'b110110, 5'h0a, 3'h6, 2'h0}};

   gcr_regs i_gcr_regs (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .reg_ack_o(reg_ack), .dma_addr_i(dma_addr), .dma_wr_i(dma_wr), .dma_wdata_i(dma_wdata),
      .dma_ack_o(dma_ack), .strap_double_res_i(strap_dbl), .strap_y_step_512_i(strap_512),
      .strap_dma_base_i(strap_base), .mem_valid_o(mem_valid), .mem_ready_i(mem_ready),
      .mem_complement_o(mem_comp), .mem_from_dma_o(mem_dma), .mem_plane_inhibit_o(mem_inh),
      .mem_x_o(mem_x), .mem_y_o(mem_y), .mem_data_o(mem_data), .clip_enable_o(clip_en),
      .video_bus_enable_o(vbus_en), .interrupt_allow_o(irq_allow),
      .double_x_resolution_o(dbl_res), .dma_mode_o(dma_mode), .frame_freeze_o(freeze),
      .blink_allow_o(blink), .lut_select_o(lut), .horizontal_zoom_factor_o(hzoom),
      .vertical_zoom_factor_o(vzoom), .dot_en_i(1'b1), .hsync_i(hsync_in),
      .hsync_o(hsync_out), .pen_strobe_i(pen_strobe), .pen_x_i(pen_x), .pen_y_i(pen_y),
      .pen_chip_read_i(pen_read), .pen_full_o(pen_full));

   gcr_host_model i_gcr_host_model (.clk_sys_i(clk_sys), .reg_addr_o(reg_addr),
      .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata),
      .reg_ack_i(reg_ack), .dma_addr_o(dma_addr), .dma_wr_o(dma_wr), .dma_wdata_o(dma_wdata),
      .dma_ack_i(dma_ack));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Memory side sink records every popped request
   always @(posedge clk_sys)
      if (rst_n && mem_valid === 1'b1 && mem_ready === 1'b1)
         seen_q.push_back({mem_dma, mem_comp, mem_inh, mem_x, mem_y, mem_data});

   task automatic chk(input string name, input logic [37:0] exp, input logic [37:0] got);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_ent(input logic [37:0] exp);
      logic [37:0] got;
      got = 'x;
      if (seen_q.size() > 0)
         got = seen_q.pop_front();
      chk("memory request", exp, got);
   endtask

   task automatic chk_reset;
      chk("reset outputs", 19'h10000, {mem_valid, clip_en, vbus_en, irq_allow, dbl_res,
         dma_mode, freeze, blink, lut, hzoom, vzoom, pen_full});
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk_sys);
      failures++;
      close_out;
   end

   initial
   begin
      rst_n = 1'b0;
      strap_dbl = 1'b0;
      strap_512 = 1'b0;
      strap_base = 8'h40;
      mem_ready = 1'b0;
      hsync_in = 1'b0;
      pen_strobe = 1'b0;
      pen_read = 1'b0;
      pen_x = 3'h0;
      pen_y = 3'h0;
      failures = 0;
      tests_run = 0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk_reset;
      foreach (rows[i])
      begin
         i_gcr_host_model.wr_ctrl(rows[i].ctrl);
         i_gcr_host_model.wr(`GCR_OFS_MAP_SEL, {12'h000, rows[i].map}, ok);
         chk("control flags", rows[i].flags,
            {blink, freeze, dma_mode, irq_allow, vbus_en, clip_en});
         chk("map select", rows[i].lut, lut);
         chk("zoom codes", {rows[i].hz, rows[i].vz}, {hzoom, vzoom});
         chk("double resolution", 1'b0, dbl_res);
      end
      strap_dbl <= 1'b1;
      i_gcr_host_model.wr_ctrl(16'h0008);
      chk("shared bit", 2'b10, {dbl_res, irq_allow});
      strap_dbl <= 1'b0;
      // Light pen capture, read-only and write-only places, unmapped read
      pen_x <= 3'h5;
      pen_y <= 3'h2;
      pen_strobe <= 1'b1;
      @(posedge clk_sys);
      pen_strobe <= 1'b0;
      @(posedge clk_sys);
      chk("pen full", 1'b1, pen_full);
      i_gcr_host_model.wr(`GCR_OFS_PEN_LOW, 16'hffff, ok);
      i_gcr_host_model.rd(`GCR_OFS_PEN_LOW, rdv);
      chk("pen low bits", 16'h0015, rdv);
      i_gcr_host_model.rd(`GCR_OFS_MAIN_CTRL, rdv);
      chk("write-only read", 16'h0000, rdv);
      i_gcr_host_model.rd(4'hf, rdv);
      chk("unmapped read", 16'h0000, rdv);
      pen_read <= 1'b1;
      @(posedge clk_sys);
      pen_read <= 1'b0;
      @(posedge clk_sys);
      chk("pen cleared", 1'b0, pen_full);
      // Host data writes fill the buffer while memory stalls
      i_gcr_host_model.wr_ctrl(16'h0001);
      i_gcr_host_model.wr(`GCR_OFS_PLANE_INH, 16'h0005, ok);
      i_gcr_host_model.wr(`GCR_OFS_X, 16'h000a, ok);
      i_gcr_host_model.wr(`GCR_OFS_Y, 16'h0014, ok);
      for (int i = 0; i < 32; i++)
      begin
         i_gcr_host_model.wr(`GCR_OFS_DATA, 16'(i), ok);
         chk("buffer take", 1'b1, ok);
      end
      i_gcr_host_model.wr(`GCR_OFS_DATA, 16'h0099, ok);
      chk("buffer full refusal", 1'b0, ok);
      mem_ready <= 1'b1;
      repeat (40) @(posedge clk_sys);
      for (int i = 0; i < 32; i++)
         chk_ent({2'b01, 4'h5, 12'h00a, 12'h014, 8'(i)});
      chk("buffer drained", 1'b0, mem_valid);
      // DMA window with automatic coordinate stepping, both portion straps
      i_gcr_host_model.wr_ctrl(16'h0010);
      i_gcr_host_model.dma(16'h4100, 8'h00, ok);
      chk("window miss", 1'b0, ok);
      for (int s = 0; s < 2; s++)
      begin
         strap_512 <= s[0];
         i_gcr_host_model.wr(`GCR_OFS_X, 16'h000f, ok);
         i_gcr_host_model.wr(`GCR_OFS_Y, 16'h0004, ok);
         for (int j = 0; j < 257; j++)
            i_gcr_host_model.dma({8'h40, 8'(j)}, 8'(j), ok);
         repeat (4) @(posedge clk_sys);
         for (int j = 0; j < 257; j++)
            chk_ent({2'b10, 4'h5, 12'(16 + j),
               (s == 0 && j == 256) ? 12'h006 : 12'h005, 8'(j)});
      end
      // Pan steps up to seven dots, then back to the normal display
      for (int p = 0; p < 8; p++)
      begin
         i_gcr_host_model.wr_ctrl({5'h00, 3'(p), 8'h00});
         hsync_in <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (hsync_out !== 1'b1 && n < 20);
         chk("sync delay", p + 2, n);
         hsync_in <= 1'b0;
         repeat (12) @(posedge clk_sys);
      end
      i_gcr_host_model.wr_ctrl(16'h3800);
      chk("normal zoom", 5'h1c, {hzoom, vzoom});
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_reset;
      rst_n <= 1'b1;
      @(posedge clk_sys);
      i_gcr_host_model.rd(`GCR_OFS_X, rdv);
      chk("x after reset", 16'h0000, rdv);
      close_out;
   end
endmodule
